// *** logic/pdr_rotate.sv ***
// Purpose: Execution-unit datapath for packed_digit_rotate_right on byte registers
// Assumes: Decoder presents the first instruction word with a one-cycle issue strobe,
//          and the register file returns both operand bytes in the issue cycle
// Notes:   Results are written back once, at the end of the nine-cycle execution
`timescale 1ns/1ps

module pdr_rotate
  import pdr_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // Instruction issue
  input  wire logic        i_issue,
  input  wire logic [15:0] i_instr,
  // Operand bytes from the register file
  input  wire logic [7:0]  i_src_byte,
  input  wire logic [7:0]  i_lnk_byte,
  // Write-back to the register file
  output logic             o_wr_en,
  output logic [3:0]       o_src_sel,
  output logic [3:0]       o_lnk_sel,
  output logic [7:0]       o_src_res,
  output logic [7:0]       o_lnk_res,
  // Flag update
  output logic             o_zero_wr,
  output logic             o_zero,
  // Status
  output logic             o_busy,
  output logic             o_illegal
);

  // ****************************************
  // Decode and datapath
  // ****************************************
  pdr_state_t state_ff;
  pdr_state_t nxt_state;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [7:0] src_ff;
  logic [7:0] lnk_ff;
  logic [3:0] ssel_ff;
  logic [3:0] lsel_ff;
  logic       wr_ff;
  logic       zero_ff;
  logic       busy_ff;
  logic       illegal_ff;

  wire logic [3:0] dec_src  = i_instr[PDR_SRC_FLD_LSB +: 4];
  wire logic [3:0] dec_lnk  = i_instr[PDR_LNK_FLD_LSB +: 4];
  wire logic       dec_hit  = i_issue && (i_instr[15:8] == PDR_OPC_HI);
  wire logic       same_reg = dec_src == dec_lnk;
  wire logic       start    = dec_hit && (state_ff == PDR_IDLE) && !same_reg;
  // Twelve-bit quantity formed from link low digit and both source digits
  wire logic [11:0] trio    = {i_lnk_byte[3:0], i_src_byte};
  wire logic [11:0] rot     = {trio[3:0], trio[11:4]};
  // Link high digit is kept; only its low digit changes
  wire logic [7:0]  new_lnk = {i_lnk_byte[7:4], i_src_byte[3:0]};
  wire logic [7:0]  new_src = {rot[7:4], rot[3:0]};
  wire logic        last    = (state_ff == PDR_BUSY) && (cnt_ff == PDR_CNT_LAST);
  // Refusal is decided only while idle; a busy unit drops every issue silently
  wire logic        refuse  = dec_hit && (state_ff == PDR_IDLE) && same_reg;
  // Zero test reads the captured link result, so late operand changes cannot alter it
  wire logic        lnk_zero = lnk_ff == 8'h00;
  wire logic        nxt_busy = nxt_state != PDR_IDLE;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      PDR_IDLE: begin
        if (start) begin
          nxt_state = PDR_BUSY;
          nxt_cnt   = 4'h1;
        end
      end
      PDR_BUSY: begin
        if (last) begin
          nxt_state = PDR_DONE;
        end else begin
          nxt_cnt = cnt_ff + 4'h1;
        end
      end
      PDR_DONE: begin
        nxt_state = PDR_IDLE;
        nxt_cnt   = PDR_CNT_RST;
      end
      default: begin
        nxt_state = PDR_IDLE;
        nxt_cnt   = PDR_CNT_RST;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_ff <= PDR_IDLE;
      cnt_ff   <= PDR_CNT_RST;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // Results and register selects captured at issue so a later register-file change cannot leak in
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      src_ff  <= PDR_BYTE_RST;
      lnk_ff  <= PDR_BYTE_RST;
      ssel_ff <= 4'h0;
      lsel_ff <= 4'h0;
    end else if (start) begin
      src_ff  <= new_src;
      lnk_ff  <= new_lnk;
      ssel_ff <= dec_src;
      lsel_ff <= dec_lnk;
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  // Every output leaves a flip-flop so the flag file sees no decode glitch;
  // busy is taken from the next state so it keeps the state register's timing.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ff      <= 1'b0;
      zero_ff    <= 1'b0;
      busy_ff    <= 1'b0;
      illegal_ff <= 1'b0;
    end else begin
      wr_ff      <= last;
      zero_ff    <= last && lnk_zero;
      busy_ff    <= nxt_busy;
      illegal_ff <= refuse;
    end
  end

  // Only the zero flag is written; carry, overflow, D and H are never touched,
  // and sign is left to the flag file as undefined.
  assign o_wr_en   = wr_ff;
  assign o_src_sel = ssel_ff;
  assign o_lnk_sel = lsel_ff;
  assign o_src_res = src_ff;
  assign o_lnk_res = lnk_ff;
  assign o_zero_wr = wr_ff;
  assign o_zero    = zero_ff;
  assign o_busy    = busy_ff;
  assign o_illegal = illegal_ff;

  // ****************************************
  // Checks
  // ****************************************
  chk_write_nine_cycles: assert property (
    @(posedge i_clk) disable iff (!i_rst_b) start |-> ##9 o_wr_en)
    else $error("write-back not nine cycles after issue");

  chk_no_early_write: assert property (
    @(posedge i_clk) disable iff (!i_rst_b) start |-> !o_wr_en [*8])
    else $error("write-back came early");

  chk_link_low_digit: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    start |-> ##9 (o_lnk_res[3:0] == $past(i_src_byte[3:0], 9)))
    else $error("link low digit wrong");

  chk_src_low_digit: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    start |-> ##9 (o_src_res[3:0] == $past(i_src_byte[7:4], 9)))
    else $error("source low digit wrong");

  chk_src_high_digit: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    start |-> ##9 (o_src_res[7:4] == $past(i_lnk_byte[3:0], 9)))
    else $error("source high digit wrong");

  chk_link_high_kept: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    start |-> ##9 (o_lnk_res[7:4] == $past(i_lnk_byte[7:4], 9)))
    else $error("link high digit changed");

  chk_zero_flag: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    start |-> ##9 (o_zero ==
      ({$past(i_lnk_byte[7:4], 9), $past(i_src_byte[3:0], 9)} == 8'h00)))
    else $error("zero flag wrong");

  chk_same_reg_refused: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (dec_hit && same_reg && !o_busy) |=> (o_illegal && !o_busy))
    else $error("same-register issue not refused");

  chk_busy_span: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    start |=> o_busy [*8] ##1 (o_busy && o_wr_en) ##1 !o_busy)
    else $error("busy span not nine cycles");

  chk_write_single: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_wr_en |=> !o_wr_en)
    else $error("write-back strobe longer than one cycle");

  chk_ignore_busy: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (dec_hit && o_busy) |=>
      ($stable(o_src_res) && $stable(o_lnk_res) && $stable(o_src_sel)))
    else $error("issue while busy disturbed the results");

  chk_zero_with_write: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    o_zero |-> o_zero_wr)
    else $error("zero flag raised without its write strobe");

endmodule : pdr_rotate

// *** inc/pdr_pkg.sv ***
// Purpose: Constants for the packed digit rotate right datapath
// Assumes: Byte register file with sixteen byte registers, 4-bit register fields
// Notes:   Opcode pattern is the first instruction word, upper byte
package pdr_pkg;
  localparam logic [7:0]  PDR_OPC_HI      = 8'hbc;
  localparam int          PDR_CYCLES      = 9;
  localparam logic [3:0]  PDR_CNT_LAST    = 4'h8;
  localparam logic [3:0]  PDR_CNT_RST     = 4'h0;
  localparam logic [7:0]  PDR_BYTE_RST    = 8'h00;
  localparam int          PDR_SRC_FLD_LSB = 4;
  localparam int          PDR_LNK_FLD_LSB = 0;

  typedef enum logic [1:0] {
    PDR_IDLE = 2'b00,
    PDR_BUSY = 2'b01,
    PDR_DONE = 2'b11
  } pdr_state_t;
endpackage : pdr_pkg

// *** sim/pdr_tb.sv ***
// Purpose: Self-checking bench for the packed digit rotate datapath
// Assumes: Write-back strobe stands between the eighth and ninth edges after taking
// Notes:   Directed values only, bench drives 1 ns after the edge
`timescale 1ns/1ps
module testbench;
  import pdr_pkg::*;
  // ****************
  // Signals
  // ****************
  logic        i_clk = 0, i_rst_b = 0, i_issue = 0;
  logic [15:0] i_instr = 16'h0000;
  logic [7:0]  i_src_byte = 8'h00, i_lnk_byte = 8'h00;
  logic        o_wr_en, o_zero_wr, o_zero, o_busy, o_illegal;
  logic [3:0]  o_src_sel, o_lnk_sel;
  logic [7:0]  o_src_res, o_lnk_res;
  int          err_count = 0, total_checks = 0;
  always #10 i_clk = ~i_clk;
  pdr_rotate dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_issue(i_issue), .i_instr(i_instr),
    .i_src_byte(i_src_byte), .i_lnk_byte(i_lnk_byte), .o_wr_en(o_wr_en),
    .o_src_sel(o_src_sel), .o_lnk_sel(o_lnk_sel), .o_src_res(o_src_res),
    .o_lnk_res(o_lnk_res), .o_zero_wr(o_zero_wr), .o_zero(o_zero), .o_busy(o_busy),
    .o_illegal(o_illegal));
  // ****************
  // Tasks
  // ****************
  task automatic chk(input string n, input logic [15:0] s, e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic issue(input logic [7:0] o, input logic [3:0] s, l, input logic [7:0] sb, lb);
    i_issue = 1;
    i_instr = {o, s, l};
    i_src_byte = sb;
    i_lnk_byte = lb;
    @(posedge i_clk);
    #1 i_issue = 0;
  endtask : issue
  // Waits from the taking edge to the write-back and judges it
  task automatic wb(input logic [3:0] s, l, input logic [7:0] sb, lb, input int pre);
    logic [7:0] el;
    el = {lb[7:4], sb[3:0]};
    repeat (7 - pre) begin
      @(posedge i_clk);
      #1 chk("early_wr", {o_wr_en, o_busy}, 2'b01);
    end
    @(posedge i_clk);
    #1 chk("wr_en", {o_wr_en, o_zero_wr, o_busy}, 3'b111);
    chk("src_res", o_src_res, {lb[3:0], sb[7:4]});
    chk("lnk_res", o_lnk_res, el);
    chk("sel", {o_src_sel, o_lnk_sel}, {s, l});
    chk("zero", o_zero, el == 8'h00);
    @(posedge i_clk);
    #1 chk("busy_end", {o_wr_en, o_zero_wr, o_zero, o_busy}, 4'h0);
  endtask : wb
  task automatic op(input logic [3:0] s, l, input logic [7:0] sb, lb);
    issue(PDR_OPC_HI, s, l, sb, lb);
    wb(s, l, sb, lb, 0);
  endtask : op
  task automatic t_rotate;
    op(4'h1, 4'h2, 8'h12, 8'h34);
    op(4'hf, 4'h0, 8'h30, 8'h90);
    $display("t_rotate done");
  endtask : t_rotate
  task automatic t_zero;
    op(4'h3, 4'h9, 8'h50, 8'h0c);
    $display("t_zero done");
  endtask : t_zero
  // Same register for both operands, then a foreign opcode
  task automatic t_refuse;
    issue(PDR_OPC_HI, 4'h5, 4'h5, 8'h12, 8'h34);
    chk("illegal", {o_illegal, o_busy}, 2'b10);
    @(posedge i_clk);
    #1 chk("illegal_end", {o_illegal, o_busy, o_wr_en}, 3'b000);
    issue(8'h3c, 4'h1, 4'h2, 8'h12, 8'h34);
    chk("other_op", {o_illegal, o_busy}, 2'b00);
    @(posedge i_clk);
    #1 $display("t_refuse done");
  endtask : t_refuse
  // A second issue while busy must not disturb the first
  task automatic t_busy;
    issue(PDR_OPC_HI, 4'h1, 4'h2, 8'h12, 8'h34);
    @(posedge i_clk);
    #1;
    issue(PDR_OPC_HI, 4'h3, 4'h4, 8'hff, 8'hff);
    wb(4'h1, 4'h2, 8'h12, 8'h34, 2);
    $display("t_busy done");
  endtask : t_busy
  // Reset in mid-operation clears everything, then an issue on the first edge
  task automatic t_reset;
    issue(PDR_OPC_HI, 4'h6, 4'h7, 8'h98, 8'h76);
    repeat (3) @(posedge i_clk);
    #1 i_rst_b = 0;
    #1 chk("async_rst", {o_busy, o_wr_en, o_illegal, o_zero}, 4'h0);
    chk("async_res", {o_src_res, o_lnk_res}, 16'h0000);
    @(posedge i_clk);
    #1 i_rst_b = 1;
    op(4'h6, 4'h7, 8'h98, 8'h76);
    $display("t_reset done");
  endtask : t_reset
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (3) @(posedge i_clk);
    #1 i_rst_b = 1;
    chk("reset", {o_busy, o_wr_en, o_illegal, o_zero, o_zero_wr}, 5'h00);
    t_rotate();
    t_zero();
    t_refuse();
    t_busy();
    t_reset();
    final_report();
  end
  // Tests need well under 200 cycles
  initial begin
    #100us;
    err_count++;
    final_report();
  end
endmodule : testbench
